/* src/dtp_top.sv */
// Thermal protection logic with an APB register slave.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module dtp_top #(
  parameter int SAMPLE_CYCLES = dtp_pkg::SAMPLE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] meas_current,
  input  wire logic [7:0]  heatsink_temp,
  input  wire logic [7:0]  chip_temp,
  input  wire logic [15:0] motor_sensor_ohms,
  output var  logic        utilization_alarm,
  output var  logic        utilization_fault,
  output var  logic        heatsink_temp_alarm,
  output var  logic        heatsink_temp_fault,
  output var  logic        chip_temp_alarm,
  output var  logic        thermal_shutdown_fault,
  output var  logic        sensor_alarm,
  output var  logic        sensor_fault,
  output var  logic        motor_overtemp_alarm,
  output var  logic        motor_overtemp_fault,
  output var  logic        motor_current_limit_reduce,
  output var  logic        current_derate,
  output var  logic        speed_derate,
  output var  logic        base_current_limit,
  output var  logic        motor_off,
  output var  logic [7:0]  pulse_freq_cmd
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [3:0]          ovl_sel;
    logic [2:0]          sens_type;
    logic [3:0]          mot_resp;
    logic                vector_mode;
    logic [7:0]          hs_margin;
    logic [7:0]          ch_margin;
    logic [7:0]          util_level;
    logic [7:0]          hs_shut;
    logic [7:0]          ch_shut;
    logic [7:0]          pf_set;
    logic [7:0]          pf_min;
    logic [15:0]         cur1;
    logic [15:0]         cur2;
    logic [7:0]          hs1;
    logic [7:0]          hs2;
    logic [7:0]          ch1;
    logic [7:0]          ch2;
    logic [15:0]         ohm1;
    logic [15:0]         ohm2;
    logic [31:0]         tick_cnt;
    logic [24:0]         acc;
    dtp_pkg::dtp_stage_e stage;
    logic [7:0]          pf;
    logic [7:0]          esc_cnt;
    logic [7:0]          sens_cnt;
    logic [7:0]          mot_cnt;
    logic                util_alarm;
    logic                util_fault;
    logic                hs_alarm;
    logic                hs_fault;
    logic                ch_alarm;
    logic                trip;
    logic                sens_alarm;
    logic                sens_fault;
    logic                mot_alarm;
    logic                mot_fault;
    logic                mot_ilim;
    logic                cur_der;
    logic                spd_der;
    logic                base_lim;
    logic                off;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } dtp_state_s;

  dtp_state_s s_q;
  dtp_state_s s_d;

  // Responses 2 and 12 run two stages; 3 and 13 reduce frequency only.
  function automatic logic dtp_two_stage(input logic [3:0] sel);
    dtp_two_stage = (sel == 4'h2) || (sel == 4'hC);
  endfunction : dtp_two_stage

  function automatic logic dtp_pf_only(input logic [3:0] sel);
    dtp_pf_only = (sel == 4'h3) || (sel == 4'hD);
  endfunction : dtp_pf_only

  logic [31:0] sq_cur;
  logic [31:0] sq_ref;
  logic [31:0] delta;
  logic [24:0] step;
  logic        tick;
  logic        overload;
  logic        mot_hot;
  logic        util_pct_hit;
  logic [7:0]  util_pct;
  logic        access;
  logic        can_reduce;

  always_comb begin
    s_d          = s_q;
    sq_cur       = 32'(s_q.cur2) * 32'(s_q.cur2);
    sq_ref       = 32'(dtp_pkg::CUR_REF) * 32'(dtp_pkg::CUR_REF);
    delta        = 32'h0000_0000;
    step         = 25'h000_0000;
    tick         = (s_q.tick_cnt == 32'(SAMPLE_CYCLES - 1));
    util_pct     = 8'((33'(s_q.acc) * 33'(dtp_pkg::PCT_FULL)) >> 24);
    util_pct_hit = (util_pct >= s_q.util_level);
    mot_hot      = 1'b0;
    access       = psel && penable && !s_q.pready;
    can_reduce   = (s_q.pf > s_q.pf_min);

    // Inputs come from the measurement front end on its own timing.
    s_d.cur1 = meas_current;
    s_d.cur2 = s_q.cur1;
    s_d.hs1  = heatsink_temp;
    s_d.hs2  = s_q.hs1;
    s_d.ch1  = chip_temp;
    s_d.ch2  = s_q.ch1;
    s_d.ohm1 = motor_sensor_ohms;
    s_d.ohm2 = s_q.ohm1;

    overload = (s_q.hs2 > s_q.hs_shut - s_q.hs_margin) ||
               (s_q.ch2 > s_q.ch_shut - s_q.ch_margin);
    // One tick per sample period keeps every threshold on one cadence.
    s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;

    // ========================================================================
    // Sampled evaluation.
    if (tick) begin
      if (s_q.cur2 > dtp_pkg::CUR_REF) begin
        delta = sq_cur - sq_ref;
        step  = 25'(delta >> dtp_pkg::UTIL_SHIFT);
        s_d.acc = (dtp_pkg::UTIL_FULL - s_q.acc <= step) ?
                  dtp_pkg::UTIL_FULL : s_q.acc + step;
      end else if (s_q.cur2 < dtp_pkg::CUR_REF) begin
        delta = sq_ref - sq_cur;
        step  = 25'(delta >> dtp_pkg::UTIL_SHIFT);
        s_d.acc = (s_q.acc <= step) ? 25'h000_0000 : s_q.acc - step;
      end
      s_d.util_alarm = util_pct_hit;
      if (s_q.acc >= dtp_pkg::UTIL_FULL) begin
        s_d.util_fault = 1'b1;
      end
      s_d.hs_alarm = s_q.hs2 > s_q.hs_shut - s_q.hs_margin;
      s_d.ch_alarm = s_q.ch2 > s_q.ch_shut - s_q.ch_margin;
      if (s_q.hs2 >= s_q.hs_shut) begin
        s_d.hs_fault = 1'b1;
      end

      // Power unit overload response.
      case (s_q.stage)
        dtp_pkg::DTP_NORMAL: begin
          s_d.esc_cnt = 8'h00;
          if (s_q.pf < s_q.pf_set) begin
            s_d.pf = s_q.pf + 8'h01;
          end else begin
            s_d.pf = s_q.pf_set;
          end
          if (overload || util_pct_hit) begin
            if (s_q.ovl_sel == 4'h1) begin
              s_d.stage = dtp_pkg::DTP_TRIP;
            end else if (s_q.ovl_sel == 4'h0) begin
              s_d.stage = dtp_pkg::DTP_DERATE;
            end else if (can_reduce) begin
              s_d.stage = dtp_pkg::DTP_PF_REDUCE;
            end else if (dtp_two_stage(s_q.ovl_sel)) begin
              s_d.stage = dtp_pkg::DTP_DERATE;
            end else begin
              s_d.stage = dtp_pkg::DTP_TRIP;
            end
          end
        end
        dtp_pkg::DTP_PF_REDUCE: begin
          if (!(overload || util_pct_hit)) begin
            s_d.stage = dtp_pkg::DTP_NORMAL;
          end else if (can_reduce) begin
            s_d.pf = s_q.pf - 8'h01;
          end else if (dtp_two_stage(s_q.ovl_sel)) begin
            s_d.stage = dtp_pkg::DTP_DERATE;
          end else begin
            s_d.stage = dtp_pkg::DTP_TRIP;
          end
        end
        dtp_pkg::DTP_DERATE: begin
          if (!(overload || util_pct_hit)) begin
            s_d.stage = dtp_pkg::DTP_NORMAL;
          end else if (s_q.esc_cnt >= dtp_pkg::ESC_SAMPLES - 8'h01) begin
            s_d.stage = dtp_pkg::DTP_TRIP;
          end else begin
            s_d.esc_cnt = s_q.esc_cnt + 8'h01;
          end
        end
        dtp_pkg::DTP_TRIP: begin
          s_d.trip = 1'b1;
        end
        default: begin
          s_d.stage = dtp_pkg::DTP_TRIP;
        end
      endcase

      // A chip at its shutdown temperature trips whatever the step chose.
      if (s_q.ch2 >= s_q.ch_shut) begin
        s_d.stage = dtp_pkg::DTP_TRIP;
      end

      // Motor sensor classification.
      s_d.sens_alarm = 1'b0;
      case (s_q.sens_type)
        dtp_pkg::SENS_SWITCH: begin
          mot_hot = (s_q.ohm2 >= dtp_pkg::SW_OPEN_OHM);
        end
        dtp_pkg::SENS_PTC: begin
          mot_hot = (s_q.ohm2 > dtp_pkg::PTC_HOT_OHM);
          s_d.sens_alarm = (s_q.ohm2 < dtp_pkg::PTC_SHORT_OHM);
        end
        default: begin
          mot_hot = 1'b0;
        end
      endcase
      if (s_d.sens_alarm) begin
        if (s_q.sens_cnt >= 8'(dtp_pkg::SENSOR_SAMPLES)) begin
          s_d.sens_fault = 1'b1;
        end else begin
          s_d.sens_cnt = s_q.sens_cnt + 8'h01;
        end
      end else begin
        s_d.sens_cnt = 8'h00;
      end
      s_d.mot_alarm = mot_hot;
      s_d.mot_ilim  = mot_hot && (s_q.mot_resp == dtp_pkg::MOT_ILIM);
      // The alarm-only response never starts the shutdown timer.
      if (mot_hot && (s_q.mot_resp != dtp_pkg::MOT_ALARM)) begin
        if (s_q.mot_cnt >= dtp_pkg::MOTOR_SAMPLES - 8'h01) begin
          s_d.mot_fault = 1'b1;
        end else begin
          s_d.mot_cnt = s_q.mot_cnt + 8'h01;
        end
      end else begin
        s_d.mot_cnt = 8'h00;
      end
    end

    // ========================================================================
    // Derived commands.
    // Derating follows the next stage, so it starts on the entering edge.
    s_d.cur_der = (s_d.stage == dtp_pkg::DTP_DERATE) && s_q.vector_mode;
    s_d.spd_der = (s_d.stage == dtp_pkg::DTP_DERATE) && !s_q.vector_mode;
    // Current is held at the setpoint's base-load value only for 2 and 3.
    s_d.base_lim = (s_q.pf_set > dtp_pkg::PF_BASE) &&
                   ((s_q.ovl_sel == 4'h2) || (s_q.ovl_sel == 4'h3));
    if (dtp_pf_only(s_q.ovl_sel) && s_q.pf_set > dtp_pkg::PF_BASE) begin
      s_d.base_lim = s_q.ovl_sel == 4'h3;
    end
    s_d.off = s_d.trip || s_d.util_fault || s_d.hs_fault ||
              s_d.sens_fault || s_d.mot_fault;

    // ========================================================================
    // APB slave; one wait state, so every access ends on its second edge.
    s_d.pready  = access;
    s_d.pslverr = 1'b0;
    if (access) begin
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        dtp_pkg::ADDR_CTRL: begin
          s_d.prdata = {7'h00, s_q.vector_mode, 4'h0, s_q.mot_resp,
                        5'h00, s_q.sens_type, 4'h0, s_q.ovl_sel};
          if (pwrite) begin
            s_d.ovl_sel     = pwdata[3:0];
            s_d.sens_type   = pwdata[10:8];
            s_d.mot_resp    = pwdata[19:16];
            s_d.vector_mode = pwdata[24];
            // A clear written on a tick is ignored, whether or not a fault is raised in that sample.
            if (pwdata[31] && !tick) begin
              s_d.trip       = 1'b0;
              s_d.util_fault = 1'b0;
              s_d.hs_fault   = 1'b0;
              s_d.sens_fault = 1'b0;
              s_d.mot_fault  = 1'b0;
              s_d.stage      = dtp_pkg::DTP_NORMAL;
            end
          end
        end
        dtp_pkg::ADDR_MARGIN: begin
          s_d.prdata = {8'h00, s_q.util_level, s_q.ch_margin, s_q.hs_margin};
          if (pwrite) begin
            s_d.hs_margin  = pwdata[7:0];
            s_d.ch_margin  = pwdata[15:8];
            s_d.util_level = pwdata[23:16];
          end
        end
        dtp_pkg::ADDR_LIMIT: begin
          s_d.prdata = {s_q.pf_min, s_q.pf_set, s_q.ch_shut, s_q.hs_shut};
          if (pwrite) begin
            s_d.hs_shut = pwdata[7:0];
            s_d.ch_shut = pwdata[15:8];
            s_d.pf_set  = pwdata[23:16];
            s_d.pf_min  = pwdata[31:24];
          end
        end
        dtp_pkg::ADDR_STATUS: begin
          s_d.prdata = {s_q.pf, util_pct, 2'h0, s_q.stage, s_q.off,
                        s_q.mot_ilim, s_q.mot_fault, s_q.mot_alarm,
                        s_q.sens_fault, s_q.sens_alarm, s_q.trip,
                        s_q.ch_alarm, s_q.hs_fault, s_q.hs_alarm,
                        s_q.util_fault, s_q.util_alarm};
        end
        dtp_pkg::ADDR_TEMPS: begin
          s_d.prdata = {16'h0000, s_q.ch2, s_q.hs2};
        end
        default: begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q             <= '0;
      s_q.ovl_sel     <= dtp_pkg::OVL_RESP_RST;
      s_q.sens_type   <= dtp_pkg::SENS_NONE;
      s_q.mot_resp    <= dtp_pkg::MOT_RESP_RST;
      s_q.vector_mode <= 1'b1;
      s_q.hs_margin   <= dtp_pkg::HS_MARGIN_RST;
      s_q.ch_margin   <= dtp_pkg::CH_MARGIN_RST;
      s_q.util_level  <= dtp_pkg::UTIL_LVL_RST;
      s_q.hs_shut     <= dtp_pkg::HS_SHUT_RST;
      s_q.ch_shut     <= dtp_pkg::CH_SHUT_RST;
      s_q.pf_set      <= dtp_pkg::PF_SET_RST;
      s_q.pf_min      <= dtp_pkg::PF_MIN_RST;
      s_q.pf          <= dtp_pkg::PF_SET_RST;
      s_q.stage       <= dtp_pkg::DTP_NORMAL;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign prdata                     = s_q.prdata;
  assign pready                     = s_q.pready;
  assign pslverr                    = s_q.pslverr;
  assign utilization_alarm          = s_q.util_alarm;
  assign utilization_fault          = s_q.util_fault;
  assign heatsink_temp_alarm        = s_q.hs_alarm;
  assign heatsink_temp_fault        = s_q.hs_fault;
  assign chip_temp_alarm            = s_q.ch_alarm;
  assign thermal_shutdown_fault     = s_q.trip;
  assign sensor_alarm               = s_q.sens_alarm;
  assign sensor_fault               = s_q.sens_fault;
  assign motor_overtemp_alarm       = s_q.mot_alarm;
  assign motor_overtemp_fault       = s_q.mot_fault;
  assign motor_current_limit_reduce = s_q.mot_ilim;
  assign current_derate             = s_q.cur_der;
  assign speed_derate               = s_q.spd_der;
  assign base_current_limit         = s_q.base_lim;
  assign motor_off                  = s_q.off;
  assign pulse_freq_cmd             = s_q.pf;

endmodule : dtp_top
`default_nettype wire

/* src/dtp_pkg.sv */
// Constants, register map and types of the drive thermal protection block.
// Function
// - Current above reference raises utilization
// - Current below reference lowers utilization, floor zero
// - Utilization warning at configured level, default 95
// - Temperature above warning threshold means overload
// - Warning threshold is margin below shutdown
// - Response 0 derates current or speed
// - Response 0 trips if derating fails
// - Response 1 trips immediately on overload
// - Response 2 lowers pulse frequency, base current held
// - Two-stage: derate when frequency reduction fails
// - Two-stage: trip when both measures fail
// - Pulse frequency returns to setpoint after overload
// - Response 3 lowers frequency only, else trips
// - Response 12 two-stage without setpoint current derating
// - Response 13 frequency only, no setpoint derating
// - Switch sensor at 100 ohm or more: overtemperature
// - PTC above 1650 ohm: overtemperature
// - PTC below 20 ohm: alarm, fault after 100 ms
// - Sensor type: none, PTC, switch
// - Motor response: alarm, limit plus timer, timer
package dtp_pkg;
  // ==========================================================================
  // Clock and timing.
  localparam int CLK_HZ         = 20_000_000;
  localparam int SAMPLE_US      = 1000;
  localparam int SAMPLE_CYC     = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int SENSOR_MS      = 100;
  localparam int SENSOR_SAMPLES = SENSOR_MS * 1000 / SAMPLE_US;
  localparam logic [7:0] ESC_SAMPLES   = 8'h0A;
  localparam logic [7:0] MOTOR_SAMPLES = 8'h64;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MARGIN = 8'h04;
  localparam logic [7:0] ADDR_LIMIT  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_TEMPS  = 8'h10;
  // ==========================================================================
  // Reset values and fixed thresholds.
  localparam logic [3:0]  OVL_RESP_RST  = 4'h2;
  localparam logic [2:0]  SENS_NONE     = 3'h0;
  localparam logic [2:0]  SENS_PTC      = 3'h1;
  localparam logic [2:0]  SENS_SWITCH   = 3'h4;
  localparam logic [3:0]  MOT_RESP_RST  = 4'hC;
  localparam logic [3:0]  MOT_ALARM     = 4'h0;
  localparam logic [3:0]  MOT_ILIM      = 4'h1;
  localparam logic [7:0]  HS_MARGIN_RST = 8'h05;
  localparam logic [7:0]  CH_MARGIN_RST = 8'h0F;
  localparam logic [7:0]  UTIL_LVL_RST  = 8'h5F;
  localparam logic [7:0]  HS_SHUT_RST   = 8'h5A;
  localparam logic [7:0]  CH_SHUT_RST   = 8'h96;
  localparam logic [7:0]  PF_SET_RST    = 8'h04;
  localparam logic [7:0]  PF_BASE       = 8'h04;
  localparam logic [7:0]  PF_MIN_RST    = 8'h02;
  localparam logic [15:0] CUR_REF       = 16'h0400;
  localparam logic [15:0] SW_OPEN_OHM   = 16'h0064;
  localparam logic [15:0] PTC_HOT_OHM   = 16'h0672;
  localparam logic [15:0] PTC_SHORT_OHM = 16'h0014;
  localparam logic [24:0] UTIL_FULL     = 25'h100_0000;
  localparam int          UTIL_SHIFT    = 8;
  localparam logic [7:0]  PCT_FULL      = 8'h64;
  // ==========================================================================
  // Overload handling stages.
  typedef enum logic [1:0] {
    DTP_NORMAL,
    DTP_PF_REDUCE,
    DTP_DERATE,
    DTP_TRIP
  } dtp_stage_e;
endpackage : dtp_pkg

/* verif/dtp_monitor.sv */
// Property checker of the drive thermal protection block.
`timescale 1ns/1ns
`default_nettype none
module dtp_monitor #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic utilization_alarm,
  input wire logic utilization_fault,
  input wire logic heatsink_temp_alarm,
  input wire logic chip_temp_alarm,
  input wire logic thermal_shutdown_fault,
  input wire logic sensor_alarm,
  input wire logic sensor_fault,
  input wire logic motor_overtemp_alarm,
  input wire logic motor_current_limit_reduce,
  input wire logic current_derate,
  input wire logic speed_derate,
  input wire logic motor_off
);
  // ==========================================================================
  // Sample period phase, counted from the release of reset.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  always_comb begin
    tick_cnt_d = tick_cnt_q + 16'h0001;
    if (tick_cnt_q == 16'(SAMPLE_CYCLES - 1)) begin
      tick_cnt_d = 16'h0000;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end
  // ==========================================================================
  // Properties.
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
  property p_ready_answer;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no pready");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
  property p_trip_off;
    thermal_shutdown_fault |-> motor_off;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("motor on");
  property p_one_derate;
    !(current_derate && speed_derate);
  endproperty
  a_one_derate: assert property (p_one_derate) else $error("two derates");
  property p_sens_esc;
    $rose(sensor_fault) |-> $past(sensor_alarm);
  endproperty
  a_sens_esc: assert property (p_sens_esc) else $error("no alarm");
  property p_util_order;
    utilization_fault |-> utilization_alarm;
  endproperty
  a_util_order: assert property (p_util_order) else $error("no warn");
  property p_tick_only;
    $rose(heatsink_temp_alarm) || $rose(chip_temp_alarm)
      |-> tick_cnt_q < 16'h0004;
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("off tick");
  property p_ilim_alarm;
    motor_current_limit_reduce |-> motor_overtemp_alarm;
  endproperty
  a_ilim_alarm: assert property (p_ilim_alarm) else $error("ilim");
  c_trip: cover property ($rose(thermal_shutdown_fault));
  c_sens: cover property ($rose(sensor_fault));
  c_speed: cover property ($rose(speed_derate));
endmodule : dtp_monitor
bind dtp_top dtp_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) dtp_monitor_i (
  .sys_clk, .rst_n, .psel, .penable, .pready, .pslverr, .utilization_alarm,
  .utilization_fault, .heatsink_temp_alarm, .chip_temp_alarm,
  .thermal_shutdown_fault, .sensor_alarm, .sensor_fault,
  .motor_overtemp_alarm, .motor_current_limit_reduce, .current_derate,
  .speed_derate, .motor_off);
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench of the drive thermal protection block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========================================================================
  // Signals and instance; a short sample period keeps the run brief.
  localparam int SC = 20;
  logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, heatsink_temp, chip_temp, pulse_freq_cmd;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] meas_current, motor_sensor_ohms;
  logic        utilization_alarm, utilization_fault, heatsink_temp_alarm;
  logic        heatsink_temp_fault, chip_temp_alarm, thermal_shutdown_fault;
  logic        sensor_alarm, sensor_fault, motor_overtemp_alarm;
  logic        motor_overtemp_fault, motor_current_limit_reduce, motor_off;
  logic        current_derate, speed_derate, base_current_limit;
  int          bad_count, comparisons;
  dtp_top #(.SAMPLE_CYCLES(SC)) dtp_top_i (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .meas_current, .heatsink_temp, .chip_temp,
    .motor_sensor_ohms, .utilization_alarm, .utilization_fault,
    .heatsink_temp_alarm, .heatsink_temp_fault, .chip_temp_alarm,
    .thermal_shutdown_fault, .sensor_alarm, .sensor_fault,
    .motor_overtemp_alarm, .motor_overtemp_fault,
    .motor_current_limit_reduce, .current_derate, .speed_derate,
    .base_current_limit, .motor_off, .pulse_freq_cmd);
  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // One idle cycle follows each transfer so psel is never set twice at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask : rd
  task automatic wt(input int t);
    repeat (t * SC) @(posedge sys_clk);
  endtask : wt
  // A clear landing on a tick is lost, so it is written twice.
  task automatic clr(input logic [31:0] c);
    apb(1'b1, 8'h00, c | 32'h8000_0000);
    apb(1'b1, 8'h00, c | 32'h8000_0000);
  endtask : clr
  task automatic cool(input logic [31:0] c);
    heatsink_temp <= 8'h19;
    wt(2);
    clr(c);
    chk({thermal_shutdown_fault, motor_off}, 32'h0000_0000);
  endtask : cool
  // ==========================================================================
  // Scenarios.
  task automatic t_reset();
    chk(pulse_freq_cmd, 32'h0000_0004);
    rd(8'h00, 32'h010C_0002);
    rd(8'h04, 32'h005F_0F05);
    rd(8'h08, 32'h0204_965A);
    rd(8'h14, 32'h0000_0000);
    chk(rerr, 32'h0000_0001);
    wt(3);
    rd(8'h0C, 32'h0400_0000);
    rd(8'h10, 32'h0000_1E19);
  endtask : t_reset
  task automatic t_resp1();
    apb(1'b1, 8'h00, 32'h0100_0001);
    heatsink_temp <= 8'h55;
    wt(3);
    chk(thermal_shutdown_fault, 32'h0000_0000);
    heatsink_temp <= 8'h56;
    wt(3);
    chk({heatsink_temp_alarm, thermal_shutdown_fault}, 32'h3);
    cool(32'h0100_0001);
  endtask : t_resp1
  task automatic t_resp0();
    apb(1'b1, 8'h00, 32'h0000_0000);
    heatsink_temp <= 8'h56;
    wt(3);
    chk({speed_derate, current_derate, motor_off}, 32'h4);
    heatsink_temp <= 8'h19;
    wt(3);
    chk(speed_derate, 32'h0000_0000);
    heatsink_temp <= 8'h56;
    wt(16);
    chk(thermal_shutdown_fault, 32'h0000_0001);
    cool(32'h0000_0000);
  endtask : t_resp0
  task automatic t_resp2();
    apb(1'b1, 8'h08, 32'h0206_965A);
    apb(1'b1, 8'h00, 32'h0100_0002);
    wt(4);
    chk({pulse_freq_cmd, base_current_limit}, 32'h0000_000D);
    heatsink_temp <= 8'h56;
    wt(2);
    chk({pulse_freq_cmd < 8'h06, current_derate}, 32'h2);
    wt(6);
    chk({pulse_freq_cmd, current_derate}, 32'h0000_0005);
    heatsink_temp <= 8'h19;
    wt(8);
    chk({pulse_freq_cmd, current_derate}, 32'h0000_000C);
    apb(1'b1, 8'h00, 32'h0100_000C);
    wt(2);
    chk(base_current_limit, 32'h0000_0000);
  endtask : t_resp2
  task automatic t_trip();
    logic [3:0] r [4] = '{4'h2, 4'hC, 4'h3, 4'hD};
    foreach (r[i]) begin
      apb(1'b1, 8'h00, {28'h010_0000, r[i]});
      heatsink_temp <= 8'h56;
      wt(25);
      chk({thermal_shutdown_fault, motor_off}, 32'h3);
      cool({28'h010_0000, r[i]});
    end
  endtask : t_trip
  task automatic t_sensor();
    clr(32'h0101_0102);
    motor_sensor_ohms <= 16'h0672;
    wt(3);
    chk(motor_overtemp_alarm, 32'h0000_0000);
    motor_sensor_ohms <= 16'h0673;
    wt(3);
    chk({motor_overtemp_alarm, motor_current_limit_reduce}, 32'h3);
    motor_sensor_ohms <= 16'h0014;
    clr(32'h0101_0102);
    wt(3);
    chk(sensor_alarm, 32'h0000_0000);
    motor_sensor_ohms <= 16'h0013;
    wt(50);
    chk({sensor_alarm, sensor_fault}, 32'h2);
    wt(55);
    chk(sensor_fault, 32'h0000_0001);
    motor_sensor_ohms <= 16'h0063;
    clr(32'h0100_0402);
    wt(3);
    chk(motor_overtemp_alarm, 32'h0000_0000);
    motor_sensor_ohms <= 16'h0064;
    wt(3);
    chk({motor_overtemp_alarm, motor_overtemp_fault}, 32'h2);
  endtask : t_sensor
  task automatic t_chip();
    chip_temp <= 8'h88;
    wt(3);
    chk({chip_temp_alarm, thermal_shutdown_fault}, 32'h2);
    chip_temp <= 8'h96;
    heatsink_temp <= 8'h5A;
    wt(3);
    chk({heatsink_temp_fault, thermal_shutdown_fault}, 32'h3);
    chip_temp <= 8'h1E;
    cool(32'h0100_0402);
  endtask : t_chip
  task automatic t_util();
    clr(32'h0100_0002);
    meas_current <= 16'hFFFF;
    wt(3);
    chk(utilization_alarm, 32'h0000_0001);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rdat[23:16] >= 8'h5F, 32'h0000_0001);
    chk(utilization_fault, 32'h0000_0001);
  endtask : t_util
  // ==========================================================================
  // Clock, sequence and watchdog.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    {rst_n, psel, penable, pwrite, paddr, pwdata, meas_current} = '0;
    heatsink_temp = 8'h19;
    chip_temp = 8'h1E;
    motor_sensor_ohms = 16'h01F4;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_resp1();
    t_resp0();
    t_resp2();
    t_trip();
    t_sensor();
    t_chip();
    t_util();
    final_report();
  end
  initial begin
    #2_000_000;
    bad_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
